// File: logic/irqfl_consts.vh
// Purpose: Offsets, field positions, reset values and codes for the request flag block
// Assumes: AHB-Lite register bus, 32-bit data, one register per aligned word
// Notes:   Definitions only
`ifndef IRQFL_CONSTS_VH
`define IRQFL_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define IRQFL_OFF_FLAGS_ONE   8'h00
`define IRQFL_OFF_FLAGS_TWO   8'h04
`define IRQFL_OFF_EDGE_FLAGS  8'h08
`define IRQFL_OFF_EDGE_SEL1   8'h0c
`define IRQFL_OFF_EDGE_SEL2   8'h10
`define IRQFL_OFF_ENABLE1     8'h14
`define IRQFL_OFF_ENABLE2     8'h18
`define IRQFL_OFF_ENABLE3     8'h1c
`define IRQFL_OFF_CONTROL     8'h20
`define IRQFL_OFF_STATUS      8'h24

// ****************************************
// Field positions and reset values
// ****************************************
`define IRQFL_B1_TIMER_A      6
`define IRQFL_B1_FIXED_ONE    4
`define IRQFL_B2_DIRECT       7
`define IRQFL_B2_CONV         6
`define IRQFL_B2_SERIAL       4
`define IRQFL_FLAGS_ONE_RST   8'h10
`define IRQFL_FLAGS_ONE_MASK  8'h4f
`define IRQFL_FLAGS_TWO_MASK  8'hd0
`define IRQFL_ENABLE1_MASK    8'h4f
`define IRQFL_ENABLE2_MASK    8'hd0
`define IRQFL_ZERO8           8'h00
`define IRQFL_TIMER_MAX       8'hff
`define IRQFL_TIMER_MIN       8'h00
`define IRQFL_CT_MASK         0
`define IRQFL_CT_DIRECT       1

// ****************************************
// Vector numbers
// ****************************************
`define IRQFL_VEC_PIN0        5'h04
`define IRQFL_VEC_SHARED      5'h08

`endif

// File: logic/irqfl_top.v
// Purpose: Sticky interrupt request flags, enables, edge selects and pin vectoring
// Assumes: One clock hclk at 200 MHz, async active-low reset, inputs synchronous to hclk
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//          Pins are sampled as they stand; bring asynchronous pins into hclk first
//          Only the pin sources are vectored; internal flags are read by software
//          The global mask resets set, so software unmasks once it is ready
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irqfl_consts.vh"

module irqfl_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire [7:0] timer_a_count,
   input wire [3:0] dedicated_pin,
   input wire [3:0] dedicated_pin_mode,
   input wire [7:0] shared_pin,
   input wire sleep_direct_transfer,
   input wire conversion_busy_bit,
   input wire serial_channel_done,
   input wire int_accept,
   output wire int_request,
   output wire [4:0] int_vector,
   output wire condition_code_mask
);

   // ****************************************
   // Helper functions
   // ****************************************
   // Shared by both pin groups and the three flag registers, so the edge
   // and clear behaviour cannot drift apart between them

   // Edge detect: 1 picks a rising edge, 0 a falling edge
   function [7:0] edge_hit;
      input [7:0] prev;
      input [7:0] now;
      input [7:0] sel;
      begin
         edge_hit = (sel & ~prev & now) | (~sel & prev & ~now);
      end
   endfunction

   // Sticky flag: set wins over a write-0 clear
   function [7:0] flag_next;
      input [7:0] cur;
      input [7:0] set;
      input wr;
      input [7:0] wdata;
      begin
         if (wr) begin
            flag_next = (cur & wdata) | set;
         end else begin
            flag_next = cur | set;
         end
      end
   endfunction

   // Word decode: only bits 7:2 of an address select a register
   function reg_hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         reg_hit = (addr[7:2] == off[7:2]);
      end
   endfunction

   // ****************************************
   // Register map
   // ****************************************
   // 00 request_flags_one: bit 6 timer A overflow, bits 3:0 dedicated pins
   //    bit 4 always reads 1, bits 7 and 5 always read 0, reset 10
   // 04 request_flags_two: bit 7 direct transfer, bit 6 conversion done
   //    bit 4 serial done, all other bits read 0, reset 00
   // 08 edge_pin_request_flags: bit n is shared edge pin n, reset 00
   // 0c edge_select_reg_one: bits 3:0 pick the edge of dedicated pins 3:0
   // 10 edge_select_reg_two: bits 7:0 pick the edge of shared pins 7:0
   //    for both selects 0 means falling and 1 rising, reset 00
   // 14 enable_reg_one: bits 6 and 3:0 writable, bit 4 reads 1
   // 18 enable_reg_two: bits 7, 6 and 4 writable
   // 1c enable_reg_three: bit n enables shared edge pin n
   // 20 control: bit 0 global mask, reset 1; bit 1 direct transfer enable
   // 24 status: bit 5 request, bits 4:0 vector, read only
   // Each register sits in the low byte of its word; bits 31:8 read 0
   // Flag bits take only writes of 0; a write of 1 leaves them unchanged

   // ****************************************
   // Bus address phase capture
   // ****************************************
   // Taken when selected, ready and NONSEQ or SEQ; hsize is ignored
   // A write lands at the end of its data phase, while hwdata stands
   reg wr_pend_r;
   reg rd_pend_r;
   reg [7:0] addr_r;
   wire phase_go;

   // Address phase qualifier
   assign phase_go = hsel & hready & htrans[1];

   // Single-cycle data phase, so no wait states are ever inserted
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         wr_pend_r <= phase_go & hwrite;
         rd_pend_r <= phase_go & ~hwrite;
         addr_r <= phase_go ? {haddr[7:2], 2'b00} : addr_r;
      end
   end

   // Zero wait states: ready is tied high and the response is always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Write strobes, one per writable register, high only in the data phase
   wire wr_f1 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_FLAGS_ONE);
   wire wr_f2 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_FLAGS_TWO);
   wire wr_f3 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_EDGE_FLAGS);
   wire wr_e1 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_EDGE_SEL1);
   wire wr_e2 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_EDGE_SEL2);
   wire wr_n1 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_ENABLE1);
   wire wr_n2 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_ENABLE2);
   wire wr_n3 = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_ENABLE3);
   wire wr_ct = wr_pend_r & reg_hit(addr_r, `IRQFL_OFF_CONTROL);

   // ****************************************
   // Configuration registers
   // ****************************************
   // Settings written by software
   reg [3:0] dedicated_edge_select_r;
   reg [7:0] shared_edge_select_r;
   reg [7:0] enable_reg_one_r;
   reg [7:0] enable_reg_two_r;
   reg [7:0] shared_pin_enable_r;
   reg direct_transfer_on_r;
   reg cc_mask_r;

   // A new select or enable counts from the edge after its data phase;
   // a pin edge in that same cycle is still judged by the old setting
   // Edge selects reset to falling; enables reset off
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dedicated_edge_select_r <= 4'h0;
         shared_edge_select_r <= 8'h00;
         enable_reg_one_r <= 8'h00;
         enable_reg_two_r <= 8'h00;
         shared_pin_enable_r <= 8'h00;
         direct_transfer_on_r <= 1'b0;
      end else begin
         if (wr_e1) begin
            dedicated_edge_select_r <= hwdata[3:0];
         end
         if (wr_e2) begin
            shared_edge_select_r <= hwdata[7:0];
         end
         if (wr_n1) begin
            enable_reg_one_r <= hwdata[7:0] & `IRQFL_ENABLE1_MASK;
         end
         if (wr_n2) begin
            enable_reg_two_r <= hwdata[7:0] & `IRQFL_ENABLE2_MASK;
         end
         if (wr_n3) begin
            shared_pin_enable_r <= hwdata[7:0];
         end
         if (wr_ct) begin
            direct_transfer_on_r <= hwdata[`IRQFL_CT_DIRECT];
         end
      end
   end

   // ****************************************
   // Event detection
   // ****************************************
   // History registers for edge and wrap detection
   reg [7:0] timer_prev_r;
   reg [3:0] ded_prev_r;
   reg [7:0] shr_prev_r;
   reg busy_prev_r;

   // Timer, pins and busy are each compared with their value one clock earlier, so a pulse
   // shorter than a clock can be missed and no synchroniser is fitted here
   // Mode gating sits after the detector, so turning interrupt mode on
   // never makes an edge by itself
   // Previous samples; pins start high as idle level of active-low request inputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_prev_r <= 8'h00;
         ded_prev_r <= 4'hf;
         shr_prev_r <= 8'hff;
         busy_prev_r <= 1'b0;
      end else begin
         timer_prev_r <= timer_a_count;
         ded_prev_r <= dedicated_pin;
         shr_prev_r <= shared_pin;
         busy_prev_r <= conversion_busy_bit;
      end
   end

   // Event strobes; timer, pin and conversion strobes are high for one cycle, direct and serial follow their input levels
   wire timer_wrap = (timer_prev_r == `IRQFL_TIMER_MAX) &
                     (timer_a_count == `IRQFL_TIMER_MIN);
   wire [7:0] ded_edges = edge_hit({4'h0, ded_prev_r}, {4'h0, dedicated_pin},
                                   {4'h0, dedicated_edge_select_r});
   wire [3:0] ded_set = ded_edges[3:0] & dedicated_pin_mode;
   // Pin level taken regardless of port direction, so port-driven edges count
   wire [7:0] shr_set = edge_hit(shr_prev_r, shared_pin, shared_edge_select_r);
   wire dt_set = sleep_direct_transfer & direct_transfer_on_r;
   wire conv_set = busy_prev_r & ~conversion_busy_bit;
   wire ser_set = serial_channel_done;

   // ****************************************
   // Request flag registers
   // ****************************************
   // Timer, direct, conversion and serial flags are readable, not vectored
   reg [7:0] request_flags_one_r;
   reg [7:0] request_flags_two_r;
   reg [7:0] edge_pin_request_flags_r;
   // Set vectors in register bit order; bits without a source stay 0
   wire [7:0] set_one = {1'b0, timer_wrap, 2'b00, ded_set};
   wire [7:0] set_two = {dt_set, conv_set, 1'b0, ser_set, 4'h0};
   // Next values before the fixed and reserved bits are forced
   wire [7:0] one_nxt = flag_next(request_flags_one_r & `IRQFL_FLAGS_ONE_MASK,
                                  set_one, wr_f1, hwdata[7:0]);
   wire [7:0] two_nxt = flag_next(request_flags_two_r, set_two, wr_f2, hwdata[7:0]);

   // A set and a write-0 clear in one cycle: the set wins, so no event is
   // lost while software clears an older one
   // Acceptance never touches the flags, only software writes of 0 do
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         request_flags_one_r <= `IRQFL_FLAGS_ONE_RST;
         request_flags_two_r <= `IRQFL_ZERO8;
         edge_pin_request_flags_r <= `IRQFL_ZERO8;
      end else begin
         request_flags_one_r <= (one_nxt & `IRQFL_FLAGS_ONE_MASK) |
                                `IRQFL_FLAGS_ONE_RST;
         request_flags_two_r <= two_nxt & `IRQFL_FLAGS_TWO_MASK;
         edge_pin_request_flags_r <= flag_next(edge_pin_request_flags_r, shr_set,
                                               wr_f3, hwdata[7:0]);
      end
   end

   // ****************************************
   // Request presentation and vectoring
   // ****************************************
   // Only the pin sources are vectored; internal flags are left to software
   // Pending sources after the individual enables
   wire [3:0] ded_pend = request_flags_one_r[3:0] & enable_reg_one_r[3:0];
   wire shr_pend = |(edge_pin_request_flags_r & shared_pin_enable_r);
   reg [4:0] vec_nxt;

   // Pin 0 wins; shared pins only when no dedicated pin pends
   always @* begin
      vec_nxt = `IRQFL_VEC_PIN0;
      if (ded_pend[0]) begin
         vec_nxt = `IRQFL_VEC_PIN0;
      end else if (ded_pend[1]) begin
         vec_nxt = `IRQFL_VEC_PIN0 + 5'h01;
      end else if (ded_pend[2]) begin
         vec_nxt = `IRQFL_VEC_PIN0 + 5'h02;
      end else if (ded_pend[3]) begin
         vec_nxt = `IRQFL_VEC_PIN0 + 5'h03;
      end else if (shr_pend) begin
         vec_nxt = `IRQFL_VEC_SHARED;
      end
   end

   // The request is a level and falls once the mask is set on entry
   wire any_pend = (|ded_pend) | shr_pend;
   assign int_request = any_pend & ~cc_mask_r;
   assign int_vector = vec_nxt;

   // Global mask: entry sets it, software may clear it via control register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cc_mask_r <= 1'b1;
      end else if (int_accept & int_request) begin
         cc_mask_r <= 1'b1;
      end else if (wr_ct) begin
         cc_mask_r <= hwdata[`IRQFL_CT_MASK];
      end
   end

   // Mask is seen by the core as well as through the control register
   assign condition_code_mask = cc_mask_r;

   // ****************************************
   // Read data
   // ****************************************
   reg [7:0] rd_r;
   reg [7:0] rd_nxt;

   // The value returned is the one that stands during the data phase;
   // a flag set at the edge that ends the read shows in the next read
   // Unmapped offsets read as zero
   always @* begin
      case (addr_r)
         `IRQFL_OFF_FLAGS_ONE: rd_nxt = request_flags_one_r;
         `IRQFL_OFF_FLAGS_TWO: rd_nxt = request_flags_two_r;
         `IRQFL_OFF_EDGE_FLAGS: rd_nxt = edge_pin_request_flags_r;
         `IRQFL_OFF_EDGE_SEL1: rd_nxt = {4'h0, dedicated_edge_select_r};
         `IRQFL_OFF_EDGE_SEL2: rd_nxt = shared_edge_select_r;
         `IRQFL_OFF_ENABLE1: rd_nxt = enable_reg_one_r | `IRQFL_FLAGS_ONE_RST;
         `IRQFL_OFF_ENABLE2: rd_nxt = enable_reg_two_r;
         `IRQFL_OFF_ENABLE3: rd_nxt = shared_pin_enable_r;
         `IRQFL_OFF_CONTROL: rd_nxt = {6'h00, direct_transfer_on_r, cc_mask_r};
         `IRQFL_OFF_STATUS: rd_nxt = {2'b00, int_request, int_vector};
         default: rd_nxt = 8'h00;
      endcase
   end

   // Copies the decoded value every clock, read or not
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_r <= 8'h00;
      end else begin
         rd_r <= rd_nxt;
      end
   end

   // Data phase value is combinational on captured address so it is current
   assign hrdata = rd_pend_r ? {24'h000000, rd_nxt} : {24'h000000, rd_r};

   // ****************************************
   // Usage hazards
   // ****************************************
   // Clear flags and enables while the mask is set: a clear that races a
   // new event leaves the flag set, and the request returns after unmask
   // All shared pins share one vector, so the handler must read the
   // shared flag register to learn which pin fired
   // A pin moved between port use and interrupt mode keeps its history, so
   // drive it to its idle level first if a stray flag would matter
   // The timer wrap is seen only if the counter is presented every clock;
   // a counter that skips from ff past 00 raises no flag
   // Conversion done is the fall of the busy level, so a busy level that
   // is already low at reset raises no flag

endmodule

`default_nettype wire

// File: dv/irqfl_chk.sv
// Purpose: Port-level assertions for the request flag block
// Assumes: Zero-wait bus, read data stands in the cycle after the address phase
// Notes:   Bound from the bench top, watches design ports only
`timescale 1ns/1ps
`default_nettype none
module irqfl_chk (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire int_accept,
   input wire int_request,
   input wire [4:0] int_vector,
   input wire condition_code_mask
);
   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_dphase_r;
   wire rd_a = hsel && hready && htrans[1] && !hwrite;
   // Write data phase marker, the only cycle in which software can change state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_dphase_r <= 1'b0;
      else
         wr_dphase_r <= hsel && hready && htrans[1] && hwrite;
   end
   AST_RD_ONE: assert property (
      rd_a && haddr[7:0] == 8'h00 |=> hrdata[5:4] == 2'b01) else $error("flags one fixed bits");
   AST_RD_TWO: assert property (
      rd_a && haddr[7:0] == 8'h04 |=> hrdata[5] == 1'b0 && hrdata[3:0] == 4'h0)
      else $error("flags two reserved bits");
   AST_REQ_MASK: assert property (
      int_request |-> !condition_code_mask) else $error("request while masked");
   AST_ACC_MASK: assert property (
      int_accept && int_request |=> condition_code_mask) else $error("mask not set on entry");
   AST_ACC_DROP: assert property (
      int_accept && int_request |=> !int_request) else $error("request kept after entry");
   AST_VEC_RANGE: assert property (
      int_request |-> int_vector >= 5'h04 && int_vector <= 5'h08) else $error("vector out of range");
   AST_STICKY: assert property (
      int_request && !int_accept && !wr_dphase_r |=> int_request) else $error("request lost");
   AST_ROSE: assert property (
      $rose(int_request) && $past(condition_code_mask) |-> $past(wr_dphase_r))
      else $error("mask dropped without write");
   cover property (int_accept && int_request);
   cover property (int_request && int_vector == 5'h08);
   cover property (int_request && int_vector == 5'h05);
endmodule
`default_nettype wire

// File: dv/irqfl_core_model.sv
// Purpose: Processor core stand-in that accepts pin requests
// Assumes: Request and vector settle before each rising edge
// Notes:   Latency input lets a scenario answer promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module irqfl_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic en,
   input wire logic [3:0] lat,
   input wire logic int_request,
   input wire logic [4:0] int_vector,
   output logic int_accept,
   output logic [4:0] last_vec
);
   logic [3:0] cnt_r;
   // ****************
   // Accept after lat cycles of steady request, one-cycle pulse
   // ****************
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 4'h0;
         int_accept <= 1'b0;
         last_vec <= 5'h00;
      end else begin
         int_accept <= 1'b0;
         cnt_r <= 4'h0;
         if (en && int_request && !int_accept && cnt_r >= lat) begin
            int_accept <= 1'b1;
            last_vec <= int_vector; // Vector taken with the accept
         end else if (en && int_request && !int_accept)
            cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

// File: dv/irqfl_tb.sv
// Purpose: Self-checking bench for the request flag block
// Assumes: Zero-wait bus slave, core model on the request side
// Notes:   Pins idle high so reset release gives no stray edges
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   logic [7:0] tmr = 8'h00, spin = 8'hff;
   logic [3:0] dpin = 4'hf, dmode = 4'h0, lat = 4'h0;
   logic slp = 1'b0, busy = 1'b0, sdone = 1'b0, en = 1'b0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, acc, req, ccm;
   wire [4:0] vec, lvec;
   int num_errors = 0, n_compared = 0, cyc = 0;
   irqfl_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_a_count(tmr), .dedicated_pin(dpin), .dedicated_pin_mode(dmode),
      .shared_pin(spin), .sleep_direct_transfer(slp), .conversion_busy_bit(busy),
      .serial_channel_done(sdone), .int_accept(acc), .int_request(req),
      .int_vector(vec), .condition_code_mask(ccm));
   irqfl_core_model u_core (.hclk(hclk), .hresetn(hresetn), .en(en), .lat(lat),
      .int_request(req), .int_vector(vec), .int_accept(acc), .last_vec(lvec));
   // ****************
   // Clock, hang guard, bus and compare helpers
   // ****************
   always #2.5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Address phase held until ready, then data phase held until ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      tick(1);
      while (hreadyout !== 1'b1) tick(1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      tick(1);
      while (hreadyout !== 1'b1) tick(1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk($sformatf("reg_%h", a), q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   // Bounded wait for the core model to take a request
   task automatic wait_acc();
      for (int i = 0; i < 60 && acc !== 1'b1; i++) tick(1);
      tick(2);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      rd(8'h00, 32'h10);
      rd(8'h0c, 32'h00);
      wr(8'h00, 8'hff);
      chk("hresp", {31'h0, hresp}, 32'h0);
      chk("mask", {31'h0, ccm}, 32'h1);
      rd(8'h00, 32'h10);
      wr(8'h04, 8'hff);
      rd(8'h04, 32'h00);
      wr(8'h08, 8'hff);
      rd(8'h08, 32'h00);
   endtask
   // Peripheral events, direct transfer held off by its enable
   task automatic t_events();
      {tmr, slp, busy, sdone} <= {8'hff, 3'b111};
      tick(1);
      {tmr, slp, busy, sdone} <= {8'h00, 3'b000};
      tick(2);
      rd(8'h04, 32'h50);
      rd(8'h00, 32'h50);
      wr(8'h00, 8'hbf);
      rd(8'h00, 32'h10);
      wr(8'h04, 8'h00);
      wr(8'h20, 8'h03);
      slp <= 1'b1;
      tick(1);
      slp <= 1'b0;
      tick(2);
      rd(8'h04, 32'h80);
   endtask
   // Dedicated pins ignored outside interrupt mode, then per-pin edges
   task automatic t_dedicated();
      dpin <= 4'h0;
      tick(2);
      rd(8'h00, 32'h10);
      dmode <= 4'hf;
      wr(8'h0c, 8'h02);
      dpin <= 4'h7;
      tick(1);
      dpin <= 4'h6;
      tick(2);
      rd(8'h00, 32'h13);
   endtask
   // Shared pins, one common vector, entry masks, flags survive
   task automatic t_shared();
      wr(8'h10, 8'h0f);
      spin <= 8'h00;
      tick(2);
      rd(8'h08, 32'hf0);
      spin <= 8'hff;
      tick(2);
      rd(8'h08, 32'hff);
      wr(8'h1c, 8'h10);
      wr(8'h20, 8'h02);
      rd(8'h24, 32'h28);
      en <= 1'b1;
      wait_acc();
      chk("vector", {27'h0, lvec}, 32'h08);
      chk("mask", {31'h0, ccm}, 32'h1);
      rd(8'h20, 32'h03);
      rd(8'h08, 32'hff);
      rd(8'h24, 32'h08);
   endtask
   // Dedicated priority with a slow core, pin 0 first then pin 1
   task automatic t_priority();
      lat <= 4'h6;
      wr(8'h1c, 8'h00);
      wr(8'h14, 8'h03);
      wr(8'h20, 8'h02);
      wait_acc();
      chk("vector", {27'h0, lvec}, 32'h04);
      chk("mask", {31'h0, ccm}, 32'h1);
      rd(8'h20, 32'h03);
      wr(8'h00, 8'h12);
      wr(8'h20, 8'h02);
      wait_acc();
      chk("vector", {27'h0, lvec}, 32'h05);
      rd(8'h00, 32'h12);
      wr(8'h14, 8'h0c);
      dpin <= 4'h8;
      tick(1);
      dpin <= 4'h0;
      tick(2);
      rd(8'h24, 32'h06);
      wr(8'h00, 8'h1a);
      rd(8'h24, 32'h07);
   endtask
   initial begin
      tick(3);
      hresetn <= 1'b1;
      tick(2);
      t_reset();
      t_events();
      t_dedicated();
      t_shared();
      t_priority();
      test_done();
   end
endmodule
bind irqfl_top irqfl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .int_accept(int_accept), .int_request(int_request), .int_vector(int_vector),
   .condition_code_mask(condition_code_mask));
`default_nettype wire
